// ---- core/pcd_decode.sv ----
// address-phase capture, positive decode, buffer tracking and master address phases
`timescale 1ns/1ps
`default_nettype none
`include "pcd_cfg.svh"
module pcd_decode
  import pcd_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        port_primary_i,
  input  wire logic        pci_frame_n_i,
  input  wire logic        pci_irdy_n_i,
  input  wire logic        pci_trdy_n_i,
  input  wire logic        pci_idsel_i,
  input  wire logic [31:0] pci_ad_i,
  input  wire logic [3:0]  primary_cmd_byte_enable_lines_i,
  input  wire pcd_win_type win_i,
  input  wire logic [2:0]  buf_release_i,
  input  wire logic        mst_req_i,
  input  wire logic [3:0]  mst_cmd_i,
  input  wire logic [63:0] mst_addr_i,
  input  wire logic        txn_ready_i,
  output logic             pci_devsel_n_o,
  output logic             pci_devsel_oe_o,
  output logic             pci_stop_n_o,
  output logic             pci_stop_oe_o,
  output logic             pci_frame_n_o,
  output logic             pci_frame_oe_o,
  output logic [31:0]      pci_ad_o,
  output logic             pci_ad_oe_o,
  output logic [3:0]       primary_cmd_byte_enable_lines_o,
  output logic             primary_cmd_byte_enable_lines_oe_o,
  output logic             mst_ack_o,
  output logic             mst_reject_o,
  output logic             txn_valid_o,
  output pcd_txn_type      txn_o,
  output logic [2:0]       buf_busy_o
);
  // two-stage synchronisers; stage one feeds stage two only
  logic [38:0] pin_s1_reg;
  logic [38:0] pin_s2_reg;
  logic        prim_s1_reg;
  logic        prim_s2_reg;
  logic        frame_prev_reg;
  logic        frame_s;
  logic        irdy_s;
  logic        trdy_s;
  logic        idsel_s;
  logic [31:0] ad_s;
  logic [3:0]  cbe_s;
  logic        frame_fall;

  pcd_tstate_type t_state_reg;
  pcd_mstate_type m_state_reg;
  logic [3:0]  cmd_reg;
  logic [63:0] addr_reg;
  logic        dual_reg;
  logic        linear;
  logic        in_pf;
  logic        in_mem;
  logic        in_io;
  logic        hit;
  logic        tgt_ok;
  logic        claim;
  logic        xfer;
  logic        txn_end;
  logic        fifo_ready;
  logic        first_done_reg;
  logic [1:0]  act_buf_reg;
  logic        buf_free;
  logic [1:0]  free_idx;
  logic [7:0]  bytes_reg [`PCD_NUM_BUF];
  logic        busy_reg  [`PCD_NUM_BUF];
  logic        buf_fills;
  logic        mst_init_ok;
  logic        mst_dual;
  logic        mst_dual_reg;
  logic [3:0]  mst_cmd_reg;
  logic [31:0] mst_hi_reg;
  logic        mst_mem;
  pcd_txn_type txn_in;

  // pins cross into the bridge clock together so they stay aligned
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_s1_reg  <= '1;
      pin_s2_reg  <= '1;
      prim_s1_reg <= 1'b0;
      prim_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= {pci_frame_n_i, pci_irdy_n_i, pci_trdy_n_i, pci_idsel_i,
                      pci_ad_i, primary_cmd_byte_enable_lines_i[2:0]};
      pin_s2_reg  <= pin_s1_reg;
      prim_s1_reg <= port_primary_i;
      prim_s2_reg <= prim_s1_reg;
    end
  end

  // the fourth command line travels in its own stage pair to keep the vector short
  logic [1:0] cbe3_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cbe3_reg <= '1;
    end else begin
      cbe3_reg <= {cbe3_reg[0], primary_cmd_byte_enable_lines_i[3]};
    end
  end

  assign {frame_s, irdy_s, trdy_s, idsel_s, ad_s} = pin_s2_reg[38:3];
  assign cbe_s      = {cbe3_reg[1], pin_s2_reg[2:0]};
  assign frame_fall = frame_prev_reg && !frame_s;
  assign xfer       = !irdy_s && !trdy_s;
  assign txn_end    = frame_s && irdy_s;

  // previous frame level for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      frame_prev_reg <= 1'b1;
    end else begin
      frame_prev_reg <= frame_s;
    end
  end

  // command and address capture, one or two address phases
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_reg  <= '0;
      addr_reg <= '0;
      dual_reg <= 1'b0;
    end else if (t_state_reg == T_IDLE && frame_fall) begin
      cmd_reg  <= cbe_s;
      addr_reg <= {32'h0000_0000, ad_s};
      dual_reg <= (cbe_s == `PCD_CMD_DAC);
    end else if (t_state_reg == T_ADDR2) begin
      cmd_reg        <= cbe_s;
      addr_reg[63:32] <= ad_s;
    end
  end

  pcd_cmd_class u_tgt_class (
    .cmd_i        (cmd_reg),
    .is_primary_i (prim_s2_reg),
    .type1_i      (addr_reg[1:0] == `PCD_LOW_TYPE1),
    .init_ok_o    (),
    .tgt_ok_o     (tgt_ok)
  );

  // positive decode: primary claims inside windows, secondaries claim what lies outside
  always_comb begin
    linear = (addr_reg[1:0] == `PCD_LOW_LINEAR);
    in_pf  = (addr_reg >= win_i.pf_base) && (addr_reg <= win_i.pf_limit);
    in_mem = (addr_reg[63:32] == 32'h0000_0000) && (addr_reg[31:0] >= win_i.mem_base) &&
             (addr_reg[31:0] <= win_i.mem_limit);
    in_io  = (addr_reg[63:32] == 32'h0000_0000) && (addr_reg[31:0] >= win_i.io_base) &&
             (addr_reg[31:0] <= win_i.io_limit);
    case (cmd_reg)
      `PCD_CMD_IORD, `PCD_CMD_IOWR: begin
        hit = prim_s2_reg ? in_io : !in_io;
      end
      `PCD_CMD_CFGRD, `PCD_CMD_CFGWR: begin
        hit = (addr_reg[1:0] == `PCD_LOW_TYPE1) || (prim_s2_reg && idsel_s);
      end
      `PCD_CMD_MRD, `PCD_CMD_MWR, `PCD_CMD_MRM, `PCD_CMD_MRL, `PCD_CMD_MWI: begin
        if (dual_reg) begin
          hit = prim_s2_reg ? in_pf : !in_pf;
        end else begin
          hit = prim_s2_reg ? (in_mem || in_pf) : !(in_mem || in_pf);
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // lowest free buffer; a claim needs one free buffer and fifo room
  always_comb begin
    buf_free = 1'b0;
    free_idx = 2'h0;
    for (int k = `PCD_NUM_BUF - 1; k >= 0; k--) begin
      if (!busy_reg[k]) begin
        buf_free = 1'b1;
        free_idx = 2'(k);
      end
    end
  end

  assign claim     = (t_state_reg == T_DECIDE) && tgt_ok && hit && buf_free && fifo_ready;
  assign buf_fills = (bytes_reg[act_buf_reg] == `PCD_BUF_BYTES - `PCD_DWORD_BYTES);

  // target sequencer: decide one clock after the last address phase
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      t_state_reg <= T_IDLE;
    end else begin
      case (t_state_reg)
        T_IDLE: begin
          if (frame_fall) begin
            t_state_reg <= (cbe_s == `PCD_CMD_DAC) ? T_ADDR2 : T_DECIDE;
          end
        end
        T_ADDR2: begin
          t_state_reg <= T_DECIDE;
        end
        T_DECIDE: begin
          t_state_reg <= claim ? T_DATA : T_WAIT;
        end
        T_DATA, T_WAIT: begin
          if (txn_end) begin
            t_state_reg <= T_IDLE;
          end
        end
        default: begin
          t_state_reg <= T_IDLE;
        end
      endcase
    end
  end

  // devsel and stop pins; devsel comes one clock after the decide step
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pci_devsel_n_o  <= 1'b1;
      pci_devsel_oe_o <= 1'b0;
      pci_stop_n_o    <= 1'b1;
      pci_stop_oe_o   <= 1'b0;
      first_done_reg  <= 1'b0;
    end else if (claim) begin
      pci_devsel_n_o  <= 1'b0;
      pci_devsel_oe_o <= 1'b1;
      pci_stop_n_o    <= 1'b1;
      pci_stop_oe_o   <= 1'b1;
      first_done_reg  <= 1'b0;
    end else if (t_state_reg == T_DATA) begin
      if (txn_end) begin
        pci_devsel_n_o  <= 1'b1;
        pci_devsel_oe_o <= 1'b0;
        pci_stop_n_o    <= 1'b1;
        pci_stop_oe_o   <= 1'b0;
      end else if (xfer) begin
        first_done_reg <= 1'b1;
        // a non-linear burst cannot go past its first data transfer
        if (!linear || buf_fills) begin
          pci_stop_n_o <= 1'b0;
        end
      end
    end
  end

  // per-buffer occupancy; a buffer owned by the running transfer ignores release
  generate
    for (genvar k = 0; k < `PCD_NUM_BUF; k++) begin : g_buf
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          busy_reg[k]  <= 1'b0;
          bytes_reg[k] <= 8'h00;
        end else if (claim && free_idx == 2'(k)) begin
          busy_reg[k]  <= 1'b1;
          bytes_reg[k] <= 8'h00;
        end else if (t_state_reg == T_DATA && act_buf_reg == 2'(k)) begin
          if (xfer && bytes_reg[k] != `PCD_BUF_BYTES) begin
            bytes_reg[k] <= bytes_reg[k] + `PCD_DWORD_BYTES;
          end
        end else if (buf_release_i[k]) begin
          busy_reg[k]  <= 1'b0;
          bytes_reg[k] <= 8'h00;
        end
      end
      assign buf_busy_o[k] = busy_reg[k];
    end
  endgenerate

  // buffer that belongs to the transfer now on the bus
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      act_buf_reg <= 2'h0;
    end else if (claim) begin
      act_buf_reg <= free_idx;
    end
  end

  // claimed transactions are queued for the forwarding side
  always_comb begin
    txn_in.cmd     = cmd_reg;
    txn_in.dual    = dual_reg;
    txn_in.addr    = addr_reg;
    txn_in.linear  = linear;
    txn_in.buf_idx = free_idx;
  end

  pcd_fifo #(
    .WIDTH ($bits(pcd_txn_type)),
    .DEPTH (`PCD_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (claim),
    .in_ready_o  (fifo_ready),
    .in_data_i   (txn_in),
    .out_valid_o (txn_valid_o),
    .out_ready_i (txn_ready_i),
    .out_data_o  (txn_o)
  );

  // master side: filter the command, then drive one or two address phases
  assign mst_dual = (mst_addr_i[63:32] != 32'h0000_0000);
  assign mst_mem  = (mst_cmd_i == `PCD_CMD_MRD) || (mst_cmd_i == `PCD_CMD_MWR) ||
                    (mst_cmd_i == `PCD_CMD_MRM) || (mst_cmd_i == `PCD_CMD_MRL) ||
                    (mst_cmd_i == `PCD_CMD_MWI);

  pcd_cmd_class u_mst_class (
    .cmd_i        (mst_cmd_i),
    .is_primary_i (prim_s2_reg),
    .type1_i      (mst_addr_i[1:0] == `PCD_LOW_TYPE1),
    .init_ok_o    (mst_init_ok),
    .tgt_ok_o     ()
  );

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      m_state_reg                        <= M_IDLE;
      pci_frame_n_o                      <= 1'b1;
      pci_frame_oe_o                     <= 1'b0;
      pci_ad_o                           <= 32'h0000_0000;
      pci_ad_oe_o                        <= 1'b0;
      primary_cmd_byte_enable_lines_o    <= 4'h0;
      primary_cmd_byte_enable_lines_oe_o <= 1'b0;
      mst_ack_o                          <= 1'b0;
      mst_reject_o                       <= 1'b0;
      mst_dual_reg                       <= 1'b0;
      mst_cmd_reg                        <= 4'h0;
      mst_hi_reg                         <= 32'h0000_0000;
    end else begin
      mst_ack_o    <= 1'b0;
      mst_reject_o <= 1'b0;
      case (m_state_reg)
        M_IDLE: begin
          // dual address only makes sense for memory commands
          if (mst_req_i && mst_init_ok && (!mst_dual || mst_mem)) begin
            m_state_reg                        <= M_ADDR1;
            mst_ack_o                          <= 1'b1;
            mst_dual_reg                       <= mst_dual;
            mst_cmd_reg                        <= mst_cmd_i;
            mst_hi_reg                         <= mst_addr_i[63:32];
            pci_frame_n_o                      <= 1'b0;
            pci_frame_oe_o                     <= 1'b1;
            pci_ad_o                           <= mst_addr_i[31:0];
            pci_ad_oe_o                        <= 1'b1;
            primary_cmd_byte_enable_lines_o    <= mst_dual ? `PCD_CMD_DAC : mst_cmd_i;
            primary_cmd_byte_enable_lines_oe_o <= 1'b1;
          end else if (mst_req_i) begin
            mst_reject_o <= 1'b1;
          end
        end
        M_ADDR1: begin
          if (mst_dual_reg) begin
            m_state_reg                     <= M_ADDR2;
            pci_ad_o                        <= mst_hi_reg;
            primary_cmd_byte_enable_lines_o <= mst_cmd_reg;
          end else begin
            m_state_reg                        <= M_IDLE;
            pci_frame_n_o                      <= 1'b1;
            pci_frame_oe_o                     <= 1'b0;
            pci_ad_oe_o                        <= 1'b0;
            primary_cmd_byte_enable_lines_oe_o <= 1'b0;
          end
        end
        default: begin
          m_state_reg                        <= M_IDLE;
          pci_frame_n_o                      <= 1'b1;
          pci_frame_oe_o                     <= 1'b0;
          pci_ad_oe_o                        <= 1'b0;
          primary_cmd_byte_enable_lines_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // checks on the decoder's own outputs and its internal decode and sequencer state
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_dac_lo;
    !pci_frame_n_o && primary_cmd_byte_enable_lines_o == `PCD_CMD_DAC;
  endsequence
  sequence s_dac_hi;
    !pci_frame_n_o && primary_cmd_byte_enable_lines_o == mst_cmd_reg && pci_ad_o == mst_hi_reg;
  endsequence

  property p_claim_room;
    claim |=> txn_valid_o && busy_reg[act_buf_reg];
  endproperty
  a_claim_room: assert property (p_claim_room) else $error("claim without room");
  property p_no_rsv_claim;
    claim |-> !(cmd_reg inside {`PCD_CMD_RSV4, `PCD_CMD_RSV5, `PCD_CMD_RSV8, `PCD_CMD_RSV9});
  endproperty
  a_no_rsv_claim: assert property (p_no_rsv_claim) else $error("reserved claimed");
  property p_no_intack;
    (claim |-> cmd_reg != `PCD_CMD_INTACK) and
    (mst_ack_o |=> primary_cmd_byte_enable_lines_o != `PCD_CMD_INTACK);
  endproperty
  a_no_intack: assert property (p_no_intack) else $error("intack handled");
  property p_no_special;
    claim |-> cmd_reg != `PCD_CMD_SPECIAL;
  endproperty
  a_no_special: assert property (p_no_special) else $error("special claimed");
  property p_cfg_side;
    claim && !prim_s2_reg |-> cmd_reg != `PCD_CMD_CFGRD;
  endproperty
  a_cfg_side: assert property (p_cfg_side) else $error("cfg read on secondary");
  property p_dac_phases;
    $rose(pci_frame_oe_o) && mst_dual_reg |-> s_dac_lo ##1 s_dac_hi ##1 pci_frame_n_o;
  endproperty
  a_dac_phases: assert property (p_dac_phases) else $error("dual phases wrong");
  property p_medium;
    claim |=> !pci_devsel_n_o && pci_devsel_oe_o;
  endproperty
  a_medium: assert property (p_medium) else $error("devsel late");
  property p_disc;
    t_state_reg == T_DATA && xfer && !linear && !txn_end && !claim |=> !pci_stop_n_o;
  endproperty
  a_disc: assert property (p_disc) else $error("no disconnect");
  property p_stop_hold;
    t_state_reg == T_DATA && first_done_reg && !linear |-> !pci_stop_n_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("disconnect dropped");
  property p_capture;
    t_state_reg == T_IDLE && frame_fall |=> t_state_reg inside {T_ADDR2, T_DECIDE} ##1
      t_state_reg inside {T_DECIDE, T_DATA, T_WAIT};
  endproperty
  a_capture: assert property (p_capture) else $error("capture order");
  property p_dac_down;
    claim && dual_reg && prim_s2_reg |-> in_pf;
  endproperty
  a_dac_down: assert property (p_dac_down) else $error("dual outside range");
endmodule
`default_nettype wire

// ---- pkg/pcd_cfg.svh ----
// command codes, buffer sizes and fifo depth for the bridge command/address decoder
`ifndef PCD_CFG_SVH
`define PCD_CFG_SVH
`define PCD_CMD_INTACK  4'h0
`define PCD_CMD_SPECIAL 4'h1
`define PCD_CMD_IORD    4'h2
`define PCD_CMD_IOWR    4'h3
`define PCD_CMD_MRD     4'h6
`define PCD_CMD_MWR     4'h7
`define PCD_CMD_CFGRD   4'hA
`define PCD_CMD_CFGWR   4'hB
`define PCD_CMD_MRM     4'hC
`define PCD_CMD_DAC     4'hD
`define PCD_CMD_MRL     4'hE
`define PCD_CMD_MWI     4'hF
`define PCD_CMD_RSV4    4'h4
`define PCD_CMD_RSV5    4'h5
`define PCD_CMD_RSV8    4'h8
`define PCD_CMD_RSV9    4'h9
`define PCD_LOW_LINEAR  2'h0
`define PCD_LOW_TYPE1   2'h1
`define PCD_NUM_BUF     3
`define PCD_BUF_BYTES   8'h80
`define PCD_DWORD_BYTES 8'h04
`define PCD_FIFO_DEPTH  16
`endif

// ---- pkg/pcd_pkg.sv ----
// types shared by the bridge command/address decoder
package pcd_pkg;
  typedef struct packed {
    logic [3:0]  cmd;
    logic        dual;
    logic [63:0] addr;
    logic        linear;
    logic [1:0]  buf_idx;
  } pcd_txn_type;
  typedef struct packed {
    logic [31:0] mem_base;
    logic [31:0] mem_limit;
    logic [31:0] io_base;
    logic [31:0] io_limit;
    logic [63:0] pf_base;
    logic [63:0] pf_limit;
  } pcd_win_type;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_ADDR2 = 3'h1, T_DECIDE = 3'h2, T_DATA = 3'h3, T_WAIT = 3'h4
  } pcd_tstate_type;
  typedef enum logic [1:0] {
    M_IDLE = 2'h0, M_ADDR1 = 2'h1, M_ADDR2 = 2'h2
  } pcd_mstate_type;
endpackage

// ---- core/pcd_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage written only on an accepted push
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- core/pcd_cmd_class.sv ----
// per-port table of which commands may be initiated and which may be claimed
`timescale 1ns/1ps
`default_nettype none
`include "pcd_cfg.svh"
module pcd_cmd_class
  import pcd_pkg::*;
(
  input  wire logic [3:0] cmd_i,
  input  wire logic       is_primary_i,
  input  wire logic       type1_i,
  output logic            init_ok_o,
  output logic            tgt_ok_o
);
  // reserved codes and interrupt acknowledge fall to the default: never either
  always_comb begin
    init_ok_o = 1'b0;
    tgt_ok_o  = 1'b0;
    case (cmd_i)
      `PCD_CMD_SPECIAL: begin
        init_ok_o = 1'b1;
      end
      `PCD_CMD_IORD, `PCD_CMD_IOWR, `PCD_CMD_MRD, `PCD_CMD_MWR,
      `PCD_CMD_MRM, `PCD_CMD_MRL, `PCD_CMD_MWI, `PCD_CMD_DAC: begin
        init_ok_o = 1'b1;
        tgt_ok_o  = 1'b1;
      end
      `PCD_CMD_CFGRD: begin
        init_ok_o = !is_primary_i;
        tgt_ok_o  = is_primary_i;
      end
      `PCD_CMD_CFGWR: begin
        // type 1 config write is also how remote special cycles are asked for
        init_ok_o = is_primary_i ? type1_i : 1'b1;
        tgt_ok_o  = is_primary_i ? 1'b1 : type1_i;
      end
      default: begin
        init_ok_o = 1'b0;
        tgt_ok_o  = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- verification/pcd_pci_init.sv ----
// pci initiator model that drives address and data phases into the decoder
`timescale 1ns/1ps
`default_nettype none
module pcd_pci_init (
  input  wire logic        clk_sys_i,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             trdy_n_o,
  output logic [31:0]      ad_o,
  output logic [3:0]       cbe_o
);
  // pulled-up controls idle high; ad/cbe idle pattern is arbitrary
  initial begin
    frame_n_o = 1'b1;
    irdy_n_o  = 1'b1;
    trdy_n_o  = 1'b1;
    ad_o      = 32'h0;
    cbe_o     = 4'h0;
  end
  // one transaction: address phase(s), a fixed decode wait, then n transfers
  task automatic run(input logic [3:0] cmd, input logic [63:0] addr, input logic dual,
                     input int n);
    @(posedge clk_sys_i);
    frame_n_o <= 1'b0;
    ad_o      <= addr[31:0];
    cbe_o     <= dual ? 4'hD : cmd;
    if (dual) begin
      @(posedge clk_sys_i);
      ad_o  <= addr[63:32];
      cbe_o <= cmd;
    end
    // released lines show the inverse so a stale value cannot pass
    @(posedge clk_sys_i);
    ad_o  <= ~ad_o;
    cbe_o <= ~cbe_o;
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      irdy_n_o  <= 1'b0;
      trdy_n_o  <= 1'b0;
      frame_n_o <= (i == n - 1);
    end
    @(posedge clk_sys_i);
    frame_n_o <= 1'b1;
    irdy_n_o  <= 1'b1;
    trdy_n_o  <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the bridge command/address decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcd_pkg::*;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, prim = 1'b1, req = 1'b0, rdy = 1'b1, idsel = 1'b1;
  logic [3:0]  mcmd = 4'h0;
  logic [63:0] maddr = 64'h0, last_addr = 64'h0;
  logic [2:0]  rel = 3'h0;
  wire logic frame_n, irdy_n, trdy_n;
  wire logic [31:0] ad;
  wire logic [3:0] cbe;
  pcd_txn_type txn;
  logic tv;
  int fails = 0, checked = 0, claims = 0, stops = 0;
  // windows overlap on purpose so each command class lands in one range
  localparam pcd_win_type WIN = '{32'h1000, 32'h1FFF, 32'h1000, 32'h1FFF,
                                  64'h1_0000_0000, 64'h1_FFFF_FFFF};
  always #2.5 clk_sys_i = ~clk_sys_i;
  pcd_pci_init PI (.clk_sys_i(clk_sys_i), .frame_n_o(frame_n), .irdy_n_o(irdy_n),
                   .trdy_n_o(trdy_n), .ad_o(ad), .cbe_o(cbe));
  pcd_decode DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .port_primary_i(prim),
    .pci_frame_n_i(frame_n), .pci_irdy_n_i(irdy_n), .pci_trdy_n_i(trdy_n),
    .pci_idsel_i(idsel), .pci_ad_i(ad), .primary_cmd_byte_enable_lines_i(cbe), .win_i(WIN),
    .buf_release_i(rel), .mst_req_i(req), .mst_cmd_i(mcmd), .mst_addr_i(maddr),
    .txn_ready_i(rdy), .pci_devsel_n_o(), .pci_devsel_oe_o(), .pci_stop_n_o(),
    .pci_stop_oe_o(), .pci_frame_n_o(), .pci_frame_oe_o(), .pci_ad_o(), .pci_ad_oe_o(),
    .primary_cmd_byte_enable_lines_o(), .primary_cmd_byte_enable_lines_oe_o(),
    .mst_ack_o(), .mst_reject_o(), .txn_valid_o(tv), .txn_o(txn), .buf_busy_o());
  // count claim and disconnect cycles; drain stalls one cycle in four
  always @(posedge clk_sys_i) begin
    claims <= claims + (DUT.pci_devsel_n_o === 1'b0 && DUT.pci_devsel_oe_o === 1'b1 &&
                        DUT.pci_stop_oe_o === 1'b1);
    stops  <= stops + (DUT.pci_stop_n_o === 1'b0);
    if (tv === 1'b1 && rdy) last_addr <= txn.addr;
    rdy <= ($urandom % 4) != 0;
  end
  function automatic logic exp_tgt(input logic [3:0] c, input logic p);
    case (c)
      4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF: return 1'b1;
      4'hA, 4'hB: return p; // type 0 only, so primary alone
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic exp_init(input logic [3:0] c, input logic p, input logic t1);
    case (c)
      4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF: return 1'b1;
      4'hA: return !p;
      4'hB: return !p || t1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic free_bufs();
    @(posedge clk_sys_i) rel <= 3'h7;
    @(posedge clk_sys_i) rel <= 3'h0;
  endtask
  // one target transaction with expected claim and disconnect outcome
  task automatic tgt(input logic p, input logic [3:0] c, input logic [63:0] a,
                     input logic d, input int n, input logic ec, input logic es);
    int c0, s0;
    @(posedge clk_sys_i) prim <= p;
    repeat (3) @(posedge clk_sys_i);
    c0 = claims;
    s0 = stops;
    PI.run(c, a, d, n);
    chk("claim", ec, claims != c0);
    chk("disconnect", es, stops != s0);
  endtask
  // master request; address phases checked at the ack and the cycle after
  task automatic mst(input logic p, input logic [3:0] c, input logic [63:0] a, input logic e);
    logic ak, rj, ph;
    ak = 0;
    rj = 0;
    ph = 0;
    @(posedge clk_sys_i);
    prim <= p;
    repeat (3) @(posedge clk_sys_i);
    req   <= 1'b1;
    mcmd  <= c;
    maddr <= a;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      req <= 1'b0;
      #1;
      if (ph) chk("phase2", {c, a[63:32]},
                  {DUT.primary_cmd_byte_enable_lines_o, DUT.pci_ad_o});
      ph = 0;
      if (DUT.mst_ack_o === 1'b1) begin
        ak = 1;
        ph = a[63:32] != 0;
        chk("phase1", {1'b0, ph ? 4'hD : c, a[31:0]},
            {DUT.pci_frame_n_o, DUT.primary_cmd_byte_enable_lines_o, DUT.pci_ad_o});
        chk("oe", 3'h7, {DUT.pci_frame_oe_o, DUT.pci_ad_oe_o,
                         DUT.primary_cmd_byte_enable_lines_oe_o});
      end
      if (DUT.mst_reject_o === 1'b1) rj = 1;
    end
    chk("ack", e, ak);
    chk("reject", !e, rj);
  endtask
  initial begin
    void'($urandom(32'ha9cd4dcc));
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 16; c++)
        if (c != 13) begin
          tgt(p, c, p ? 32'h1000 + ($urandom & 32'hFFC) : 32'h8000_0000,
              0, 1, exp_tgt(c, p), 0);
          free_bufs();
        end
    // type 0 config on the primary needs idsel; a type 1 config write on a secondary is claimed
    @(posedge clk_sys_i) idsel <= 1'b0;
    tgt(1, 4'hA, 64'h1000, 0, 1, 0, 0);
    @(posedge clk_sys_i) idsel <= 1'b1;
    tgt(0, 4'hB, 64'h8000_0001, 0, 1, 1, 1);
    free_bufs();
    tgt(1, 4'h7, 64'h1002, 0, 2, 1, 1);
    tgt(1, 4'h7, 64'h1004, 0, 2, 1, 0);
    tgt(1, 4'h6, 64'h1_0000_1000, 1, 1, 1, 0);
    chk("dual addr", 64'h1_0000_1000, last_addr);
    free_bufs();
    tgt(1, 4'h6, 64'h2_0000_0000, 1, 1, 0, 0);
    tgt(0, 4'h6, 64'h2_0000_0000, 1, 1, 1, 0);
    tgt(0, 4'h6, 64'h1_0000_1000, 1, 1, 0, 0);
    tgt(1, 4'h7, 64'h1000, 0, 32, 1, 1);
    free_bufs();
    for (int i = 0; i < 4; i++) tgt(1, 4'h7, 64'h1000, 0, 1, i < 3, 0);
    chk("busy", 3'h7, DUT.buf_busy_o);
    free_bufs();
    for (int p = 0; p < 2; p++)
      for (int t = 0; t < 2; t++)
        for (int c = 0; c < 16; c++)
          if (c != 13)
            mst(p, c, {(c inside {6, 7, 12, 14, 15}) ? $urandom | 32'h1 : 32'h0,
                $urandom & 32'hFFFF_FFFC | t}, exp_init(c, p, t));
    give_verdict();
  end
  // watchdog well beyond the roughly 1500 cycles the sequence needs
  initial begin
    #200us;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
